// ### core/bcb_pkg.sv
package bcb_pkg;

	// Register numbers with fixed roles
	localparam logic [3:0] LINK_REG_NUM = 4'hE;
	localparam logic [3:0] PC_REG_NUM = 4'hF;
	localparam logic [3:0] LOW_REG_LIMIT = 4'h8;

	// Link value for the register call is the program counter minus this
	localparam logic [31:0] CALL_REG_LINK_BACK = 32'h0000_0002;

	// Upper nibble that marks a possible exception-return target
	localparam logic [3:0] EXC_RETURN_PREFIX = 4'hF;

	// Condition flag positions within the 4-bit flag word
	localparam int FLAG_N_POS = 3;
	localparam int FLAG_Z_POS = 2;
	localparam int FLAG_C_POS = 1;
	localparam int FLAG_V_POS = 0;
	localparam logic [3:0] FLAGS_RESET = 4'h0;

	// Short-form opcode fields, matched on the top bits of halfword one, except the low [2:0] check
	localparam logic [8:0] OP_BRANCH_REG = 9'h08E;    // [15:7]
	localparam logic [8:0] OP_CALL_REG = 9'h08F;      // [15:7]
	localparam logic [9:0] OP_CMP_NEG = 10'h10B;      // [15:6]
	localparam logic [9:0] OP_CMP_REG_LO = 10'h10A;   // [15:6]
	localparam logic [7:0] OP_CMP_REG_HI = 8'h45;     // [15:8]
	localparam logic [7:0] OP_MOVE_REG = 8'h46;       // [15:8]
	localparam logic [4:0] OP_CMP_IMM = 5'h05;        // [15:11]
	localparam logic [2:0] BRANCH_LOW_ZERO = 3'h0;    // [2:0]

	// Long-form call: halfword one [15:11], halfword two [15:14] and [12]
	localparam logic [4:0] OP_CALL_IMM_HI = 5'h1E;
	localparam logic [1:0] OP_CALL_IMM_LO = 2'h3;

	// Barrier prefix: halfword one [15:4], halfword two [15:14] and [12]
	localparam logic [11:0] OP_BARRIER_HI = 12'hF3B;
	localparam logic [1:0] OP_BARRIER_LO = 2'h2;
	localparam logic [3:0] BARRIER_SEL_ORDER = 4'h5;  // halfword two [7:4]
	localparam logic [3:0] BARRIER_SEL_COMPLETE = 4'h4;
	localparam logic [3:0] FULL_SYSTEM_OPTION = 4'hF;

	typedef enum logic [0:0] {
		BCB_RUN,
		BCB_DRAIN
	} bcb_state_t;

endpackage

// ### core/bcb_flag_adder.sv
`timescale 1ns/1ps

// 32-bit add with carry-in, giving the four condition flags
module bcb_flag_adder (
	input wire logic [31:0] op_a,
	input wire logic [31:0] op_b,
	input wire logic carry_in,
	output logic [31:0] sum,
	output logic flag_n,
	output logic flag_z,
	output logic flag_c,
	output logic flag_v
);
	logic [32:0] wide;

	// Carry from the 33rd bit, overflow from operand and result signs
	always_comb begin
		wide = {1'b0, op_a} + {1'b0, op_b} + {32'h0000_0000, carry_in};
		sum = wide[31:0];
		flag_n = wide[31];
		flag_z = (wide[31:0] == 32'h0000_0000);
		flag_c = wide[32];
		flag_v = (op_a[31] == op_b[31]) && (wide[31] != op_a[31]);
	end
endmodule

// ### core/bcb_exec.sv
`timescale 1ns/1ps

// Behaviour
// - Immediate call links next address with bit 0 set, branches PC+offset.
// - Immediate call runs only as one whole 32-bit instruction, never halves.
// - Register call takes target from register, links PC minus 2, bit0 set.
// - Leaving compact state faults on the target instruction, not the branch.
// - Register branch without link to a target whose upper nibble is F is flagged as possible exception return.
// - Register branch naming register 15 is unpredictable.
// - Register call naming register 15 is unpredictable.
// - Compare-negative adds operands, carry-in zero, sets all four flags.
// - Compare-immediate adds inverted immediate plus one, sets four flags.
// - Short compare-immediate carries an unsigned byte, zero to 255.
// - First register compare uses 3-bit fields, registers 0 to 7 only.
// - Second register compare: high bit joins field; unpredictable cases.
// - Copy synonym decodes exactly as the register move.
// - Memory barrier orders earlier explicit accesses before later ones.
// - Memory barrier never stalls non-memory instructions.
// - Every memory barrier option executes as the full-system barrier.
// - Completion barrier holds back all later instructions until done.
// - Completion barrier ends when accesses and maintenance are finished.
// - Every completion barrier option executes as full-system barrier.
// - Call offset built from sign, derived jump bits, fields, zero LSB.
module bcb_exec
	import bcb_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic instr_valid,
	output logic instr_ready,
	input wire logic [31:0] instr,
	input wire logic instr_is32,
	input wire logic [31:0] program_counter,
	output logic [3:0] rf_addr_a,
	output logic [3:0] rf_addr_b,
	input wire logic [31:0] rf_data_a,
	input wire logic [31:0] rf_data_b,
	input wire logic mem_idle,
	input wire logic maint_idle,
	output logic mem_fence,
	output logic barrier_done,
	output logic flags_we,
	output logic [3:0] condition_flags,
	output logic link_we,
	output logic [31:0] link_register,
	output logic branch_valid,
	output logic [31:0] branch_target,
	output logic branch_state_fault,
	output logic exc_return_hint,
	output logic rd_we,
	output logic [3:0] rd_addr,
	output logic [31:0] rd_data,
	output logic unpredictable,
	output logic undefined
);
	typedef struct packed {
		bcb_state_t st;
		logic fence;
		logic done;
		logic flags_we;
		logic [3:0] flags;
		logic link_we;
		logic [31:0] link;
		logic br_valid;
		logic [31:0] br_target;
		logic br_fault;
		logic exc_ret;
		logic rd_we;
		logic [3:0] rd_addr;
		logic [31:0] rd_data;
		logic unpred;
		logic undef;
	} bcb_regs_t;

	bcb_regs_t regs_r;
	bcb_regs_t regs_nxt;

	logic [15:0] hw1;
	logic [15:0] hw2;
	logic take;
	logic is_branch_reg;
	logic is_call_reg;
	logic is_cmp_neg;
	logic is_cmp_imm;
	logic is_cmp_lo;
	logic is_cmp_hi;
	logic is_move;
	logic is_call_imm;
	logic is_barrier;
	logic [3:0] cmp_hi_first;
	logic [3:0] cmp_hi_second;
	logic [31:0] byte_immediate;
	logic offset_sign;
	logic derived_i1;
	logic derived_i2;
	logic [31:0] call_offset;
	logic [31:0] call_reg_link;
	logic [31:0] add_b;
	logic add_cin;
	logic [31:0] add_sum;
	logic add_n;
	logic add_z;
	logic add_c;
	logic add_v;

	// Halfword one sits in the upper half for both widths
	assign hw1 = instr[31:16];
	assign hw2 = instr[15:0];
	assign take = instr_valid && instr_ready;

	// Only the drain state refuses instructions
	assign instr_ready = (regs_r.st == BCB_RUN);

	// Opcode recognition, short forms first, then the long forms
	assign is_branch_reg = !instr_is32 && (hw1[15:7] == OP_BRANCH_REG)
		&& (hw1[2:0] == BRANCH_LOW_ZERO);
	assign is_call_reg = !instr_is32 && (hw1[15:7] == OP_CALL_REG)
		&& (hw1[2:0] == BRANCH_LOW_ZERO);
	assign is_cmp_neg = !instr_is32 && (hw1[15:6] == OP_CMP_NEG);
	assign is_cmp_lo = !instr_is32 && (hw1[15:6] == OP_CMP_REG_LO);
	assign is_cmp_hi = !instr_is32 && (hw1[15:8] == OP_CMP_REG_HI);
	assign is_cmp_imm = !instr_is32 && (hw1[15:11] == OP_CMP_IMM);
	// Copy synonym has no encoding of its own: it arrives as this move
	assign is_move = !instr_is32 && (hw1[15:8] == OP_MOVE_REG);
	// Call prefix seen as a lone halfword is refused, not half-executed
	assign is_call_imm = instr_is32 && (hw1[15:11] == OP_CALL_IMM_HI)
		&& (hw2[15:14] == OP_CALL_IMM_LO) && hw2[12];
	assign is_barrier = instr_is32 && (hw1[15:4] == OP_BARRIER_HI)
		&& (hw2[15:14] == OP_BARRIER_LO) && !hw2[12];

	// High compare: extra bit joins the 3-bit first field
	assign cmp_hi_first = {hw1[7], hw1[2:0]};
	assign cmp_hi_second = hw1[6:3];
	assign byte_immediate = {24'h00_0000, hw1[7:0]};

	// Call offset: S, I1, I2, imm10, imm11, zero, sign-extended
	assign offset_sign = hw1[10];
	assign derived_i1 = ~(hw2[13] ^ offset_sign);
	assign derived_i2 = ~(hw2[11] ^ offset_sign);
	assign call_offset = {{7{offset_sign}}, offset_sign, derived_i1,
		derived_i2, hw1[9:0], hw2[10:0], 1'b0};
	assign call_reg_link = program_counter - CALL_REG_LINK_BACK;

	// Register read addresses; low forms pad a zero bit on top
	always_comb begin
		rf_addr_a = {1'b0, hw1[2:0]};
		rf_addr_b = {1'b0, hw1[5:3]};
		if (is_cmp_imm) begin
			rf_addr_a = {1'b0, hw1[10:8]};
		end else if (is_cmp_hi) begin
			rf_addr_a = cmp_hi_first;
			rf_addr_b = cmp_hi_second;
		end else if (is_branch_reg || is_call_reg || is_move) begin
			rf_addr_a = hw1[6:3];
		end
	end

	// Compare-negative adds straight; compares add the inverse plus one
	always_comb begin
		add_b = ~rf_data_b;
		add_cin = 1'b1;
		if (is_cmp_neg) begin
			add_b = rf_data_b;
			add_cin = 1'b0;
		end else if (is_cmp_imm) begin
			add_b = ~byte_immediate;
		end
	end

	// One shared adder serves all four compare flavours
	bcb_flag_adder u_adder (
		.op_a(rf_data_a),
		.op_b(add_b),
		.carry_in(add_cin),
		.sum(add_sum),
		.flag_n(add_n),
		.flag_z(add_z),
		.flag_c(add_c),
		.flag_v(add_v)
	);

	// Next state; result strobes are one-cycle pulses by default
	always_comb begin
		regs_nxt = regs_r;
		regs_nxt.done = 1'b0;
		regs_nxt.flags_we = 1'b0;
		regs_nxt.link_we = 1'b0;
		regs_nxt.br_valid = 1'b0;
		regs_nxt.br_fault = 1'b0;
		regs_nxt.exc_ret = 1'b0;
		regs_nxt.rd_we = 1'b0;
		regs_nxt.unpred = 1'b0;
		regs_nxt.undef = 1'b0;

		// Fence drops once earlier accesses have drained
		if (mem_idle) begin
			regs_nxt.fence = 1'b0;
		end

		case (regs_r.st)
		BCB_RUN: begin
			if (take) begin
				if (is_call_imm) begin
					regs_nxt.link_we = 1'b1;
					regs_nxt.link = {program_counter[31:1], 1'b1};
					regs_nxt.br_valid = 1'b1;
					regs_nxt.br_target = program_counter + call_offset;
				end else if (is_call_reg) begin
					if (hw1[6:3] == PC_REG_NUM) begin
						regs_nxt.unpred = 1'b1;
					end else begin
						regs_nxt.link_we = 1'b1;
						regs_nxt.link = {call_reg_link[31:1], 1'b1};
						regs_nxt.br_valid = 1'b1;
						regs_nxt.br_target = {rf_data_a[31:1], 1'b0};
						// Fault rides with the target, not this branch
						regs_nxt.br_fault = !rf_data_a[0];
					end
				end else if (is_branch_reg) begin
					if (hw1[6:3] == PC_REG_NUM) begin
						regs_nxt.unpred = 1'b1;
					end else begin
						regs_nxt.br_valid = 1'b1;
						regs_nxt.br_target = {rf_data_a[31:1], 1'b0};
						regs_nxt.br_fault = !rf_data_a[0];
						regs_nxt.exc_ret =
							(rf_data_a[31:28] == EXC_RETURN_PREFIX);
					end
				end else if (is_cmp_hi && ((cmp_hi_first < LOW_REG_LIMIT
						&& cmp_hi_second < LOW_REG_LIMIT)
						|| cmp_hi_first == PC_REG_NUM
						|| cmp_hi_second == PC_REG_NUM)) begin
					// Flags left untouched on an unpredictable compare
					regs_nxt.unpred = 1'b1;
				end else if (is_cmp_neg || is_cmp_imm || is_cmp_lo
						|| is_cmp_hi) begin
					// Sum is discarded; only the flags leave the block
					regs_nxt.flags_we = 1'b1;
					regs_nxt.flags[FLAG_N_POS] = add_n;
					regs_nxt.flags[FLAG_Z_POS] = add_z;
					regs_nxt.flags[FLAG_C_POS] = add_c;
					regs_nxt.flags[FLAG_V_POS] = add_v;
				end else if (is_move) begin
					regs_nxt.rd_we = 1'b1;
					regs_nxt.rd_addr = {hw1[7], hw1[2:0]};
					regs_nxt.rd_data = rf_data_a;
				end else if (is_barrier
						&& hw2[7:4] == BARRIER_SEL_ORDER) begin
					// Option ignored: every value acts as full system
					regs_nxt.fence = 1'b1;
					regs_nxt.done = 1'b1;
				end else if (is_barrier
						&& hw2[7:4] == BARRIER_SEL_COMPLETE) begin
					// Option ignored here too, always full system
					regs_nxt.st = BCB_DRAIN;
				end else begin
					regs_nxt.undef = 1'b1;
				end
			end
		end
		BCB_DRAIN: begin
			// Release only when accesses and maintenance have ended
			if (mem_idle && maint_idle) begin
				regs_nxt.st = BCB_RUN;
				regs_nxt.done = 1'b1;
			end
		end
		default: begin
			regs_nxt.st = BCB_RUN;
		end
		endcase
	end

	// Single register stage for the whole state word
	always_ff @(posedge clk) begin
		if (srst) begin
			regs_r <= '0;
			regs_r.st <= BCB_RUN;
			regs_r.flags <= FLAGS_RESET;
		end else begin
			regs_r <= regs_nxt;
		end
	end

	// Outputs other than the read addresses come straight from the state word
	assign mem_fence = regs_r.fence;
	assign barrier_done = regs_r.done;
	assign flags_we = regs_r.flags_we;
	assign condition_flags = regs_r.flags;
	assign link_we = regs_r.link_we;
	assign link_register = regs_r.link;
	assign branch_valid = regs_r.br_valid;
	assign branch_target = regs_r.br_target;
	assign branch_state_fault = regs_r.br_fault;
	assign exc_return_hint = regs_r.exc_ret;
	assign rd_we = regs_r.rd_we;
	assign rd_addr = regs_r.rd_addr;
	assign rd_data = regs_r.rd_data;
	assign unpredictable = regs_r.unpred;
	assign undefined = regs_r.undef;
endmodule

// ### sim/bcb_exec_properties.sv
`timescale 1ns/1ps
module bcb_exec_properties
	import bcb_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire logic [31:0] instr,
	input wire logic instr_is32,
	input wire logic [31:0] program_counter,
	input wire logic [3:0] rf_addr_a,
	input wire logic [31:0] rf_data_a,
	input wire logic [31:0] rf_data_b,
	input wire logic mem_idle,
	input wire logic maint_idle,
	input wire logic mem_fence,
	input wire logic barrier_done,
	input wire logic flags_we,
	input wire logic [3:0] condition_flags,
	input wire logic link_we,
	input wire logic [31:0] link_register,
	input wire logic branch_valid,
	input wire logic branch_state_fault,
	input wire logic unpredictable,
	input wire logic rd_we,
	input wire logic [31:0] rd_data
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic [15:0] h;
	logic tk, t16, cmpi, compare_negative, call, call_with_link_register, bx15, register_move, bar, zhit, add_n, rm0;
	logic [31:0] rm_val, rn_val, sum;
	// Decode of a taken instruction, halfword one on top
	assign h = instr[31:16];
	assign tk = instr_valid && instr_ready;
	assign t16 = tk && !instr_is32;
	assign cmpi = t16 && h[15:11] == OP_CMP_IMM;
	assign compare_negative = t16 && h[15:6] == OP_CMP_NEG;
	assign call = tk && instr_is32 && h[15:11] == OP_CALL_IMM_HI
		&& instr[15:14] == OP_CALL_IMM_LO && instr[12];
	assign call_with_link_register = t16 && h[15:7] == OP_CALL_REG && h[6:3] != PC_REG_NUM
		&& h[2:0] == BRANCH_LOW_ZERO;
	assign bx15 = t16 && h[15:3] == {OP_BRANCH_REG, PC_REG_NUM}
		&& h[2:0] == BRANCH_LOW_ZERO;
	assign register_move = t16 && h[15:8] == OP_MOVE_REG;
	assign bar = tk && instr_is32 && h[15:4] == OP_BARRIER_HI
		&& instr[15:14] == OP_BARRIER_LO && !instr[12];
	// Port choice for reads is the design's, so follow the address
	assign rm_val = rf_addr_a == h[6:3] ? rf_data_a : rf_data_b;
	assign rn_val = rf_addr_a == {1'h0, h[10:8]} ? rf_data_a : rf_data_b;
	assign zhit = rn_val == {24'h0, h[7:0]};
	assign sum = rf_data_a + rf_data_b;
	assign add_n = sum[31];
	assign rm0 = rm_val[0];
	sequence s_drain;
		!instr_ready && mem_idle && maint_idle;
	endsequence
	sequence s_release;
		barrier_done && instr_ready;
	endsequence
	AST_CMPI_ZERO: assert property (cmpi |=> flags_we &&
		condition_flags[FLAG_Z_POS] == $past(zhit)) else $error("cmp z");
	AST_CMN_NEG: assert property (compare_negative |=> flags_we &&
		condition_flags[FLAG_N_POS] == $past(add_n)) else $error("cmn n");
	AST_CALL_LINK: assert property (call |=> link_we &&
		link_register == ($past(program_counter) | 32'h1)) else $error("bl");
	AST_REG_CALL: assert property (call_with_link_register |=> link_register ==
		(($past(program_counter) - 32'h2) | 32'h1)) else $error("blx link");
	AST_REG_FAULT: assert property (call_with_link_register |=> branch_valid &&
		branch_state_fault == !$past(rm0)) else $error("blx fault");
	AST_BX_PC: assert property (bx15 |=> unpredictable
		&& !branch_valid) else $error("bx pc");
	AST_MOVE: assert property (register_move |=> rd_we &&
		rd_data == $past(rm_val)) else $error("move");
	AST_ORDER: assert property (bar && instr[7:4] == BARRIER_SEL_ORDER
		|=> barrier_done && mem_fence && instr_ready) else $error("order");
	AST_HOLD: assert property (bar && instr[7:4] == BARRIER_SEL_COMPLETE
		|=> !instr_ready && !barrier_done) else $error("hold");
	AST_RELEASE: assert property (s_drain |=> s_release)
		else $error("release");
	AST_WAIT: assert property (!instr_ready && !(mem_idle && maint_idle)
		|=> !instr_ready && !barrier_done) else $error("early done");
endmodule

bind bcb_exec bcb_exec_properties i_prop (.*);

// ### sim/bcb_far_model.sv
`timescale 1ns/1ps
// Register file and memory system on the far side of the execute block
module bcb_far_model (
	input wire logic clk,
	input wire logic srst,
	input wire logic kick,
	input wire logic [3:0] mem_len,
	input wire logic [3:0] maint_len,
	input wire logic [3:0] rf_addr_a,
	input wire logic [3:0] rf_addr_b,
	output logic [31:0] rf_data_a,
	output logic [31:0] rf_data_b,
	output logic mem_idle,
	output logic maint_idle
);
	logic [31:0] regs [16];
	logic [3:0] mem_cnt, maint_cnt;
	// Same-cycle reads, as the execute block expects
	assign rf_data_a = regs[rf_addr_a];
	assign rf_data_b = regs[rf_addr_b];
	// Outstanding work drains one step a cycle; long counts make it slow
	always @(posedge clk) begin
		if (srst || kick) begin
			mem_cnt <= srst ? 4'h0 : mem_len;
			maint_cnt <= srst ? 4'h0 : maint_len;
		end else begin
			mem_cnt <= mem_cnt - (mem_cnt != 4'h0);
			maint_cnt <= maint_cnt - (maint_cnt != 4'h0);
		end
	end
	assign mem_idle = mem_cnt == 4'h0;
	assign maint_idle = maint_cnt == 4'h0;
endmodule

// ### sim/bcb_exec_tb.sv
`timescale 1ns/1ps
module bcb_exec_tb;
	logic clk, srst, instr_valid, instr_is32, kick, mem_idle, maint_idle;
	logic instr_ready, mem_fence, barrier_done, flags_we, link_we;
	logic branch_valid, branch_state_fault, exc_return_hint, rd_we;
	logic unpredictable, undefined;
	logic [31:0] instr, program_counter, rf_data_a, rf_data_b, pc;
	logic [31:0] link_register, branch_target, rd_data;
	logic [3:0] rf_addr_a, rf_addr_b, mem_len, maint_len;
	logic [3:0] condition_flags, rd_addr;
	int fail_count, n_compared;

	bcb_exec i_dut (.*);
	bcb_far_model i_far (.*);

	// Free-running core clock
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	// One instruction offered for one cycle; results read after the take
	task issue(input logic [31:0] i, input logic w);
		@(posedge clk);
		instr_valid <= 1'h1;
		instr <= i;
		instr_is32 <= w;
		program_counter <= pc;
		@(posedge clk);
		instr_valid <= 1'h0;
		#1;
	endtask

	// Loads outstanding memory and maintenance work into the far side
	task busy(input logic [3:0] m, input logic [3:0] k);
		@(posedge clk);
		kick <= 1'h1;
		mem_len <= m;
		maint_len <= k;
		@(posedge clk);
		kick <= 1'h0;
	endtask

	task t_compare;
		logic [11:0] tv [3];
		tv = '{12'h002, 12'hFF8, 12'h806};
		i_far.regs[3] = 32'h0000_0080;
		for (int k = 0; k < 3; k++) begin
			issue({8'h2B, tv[k][11:4], 16'h0}, 1'h0);
			chk("cmpi", {1'h1, tv[k][3:0]}, {flags_we, condition_flags});
		end
		i_far.regs[1] = 32'h8000_0000;
		i_far.regs[2] = 32'h8000_0000;
		i_far.regs[13] = 32'h0000_0080;
		issue(32'h42D1_0000, 1'h0);
		chk("cmn", 4'h7, condition_flags);
		issue(32'h4291_0000, 1'h0);
		chk("cmp_lo", 4'h6, condition_flags);
		issue(32'h459D_0000, 1'h0);
		chk("cmp_sp", 5'h16, {flags_we, condition_flags});
		issue(32'h4511_0000, 1'h0);
		chk("cmp_both_low", 2'h1, {flags_we, unpredictable});
		issue(32'h459F_0000, 1'h0);
		chk("cmp_pc", 2'h1, {flags_we, unpredictable});
	endtask

	task t_branch;
		issue(32'hF7FF_FFFE, 1'h1);
		chk("bl_link", 32'h0000_1005, link_register);
		chk("bl_back", 32'h0000_1000, branch_target);
		issue(32'hF000_D001, 1'h1);
		chk("bl_far", 32'h00C0_1006, branch_target);
		issue(32'hF000_0000, 1'h0);
		chk("bl_half", 2'h1, {branch_valid, undefined});
		i_far.regs[4] = 32'h0000_2001;
		i_far.regs[5] = 32'hFFFF_FFF8;
		pc = 32'h0000_2004;
		issue(32'h47A0_0000, 1'h0);
		chk("blx_link", 32'h0000_2003, link_register);
		chk("blx_tgt", 32'h0000_2000, branch_target);
		issue(32'h4728_0000, 1'h0);
		chk("bx_ret", 3'h7, {branch_valid, exc_return_hint,
			branch_state_fault});
		issue(32'h4778_0000, 1'h0);
		chk("bx_pc", 2'h1, {branch_valid, unpredictable});
		issue(32'h47F8_0000, 1'h0);
		chk("blx_pc", 2'h1, {link_we, unpredictable});
		issue(32'h46A1_0000, 1'h0);
		chk("copy_we", 1'h1, rd_we);
		chk("copy", 32'h0000_2001, rd_data);
		chk("copy_dst", 4'h9, rd_addr);
	endtask

	task t_barrier;
		int n;
		for (int o = 0; o < 16; o++) begin
			busy(4'h3, 4'h0);
			issue(32'hF3BF_8F50 | o, 1'h1);
			chk("mem_order", 3'h7, {barrier_done, mem_fence,
				instr_ready});
			busy(4'(o % 4), 4'(o));
			issue(32'hF3BF_8F40 | o, 1'h1);
			chk("drain", 2'h0, {instr_ready, barrier_done});
			n = 0;
			while (barrier_done !== 1'h1 && n < 40) begin
				@(posedge clk);
				#1;
				n++;
			end
			chk("complete", 3'h7, {instr_ready, mem_idle,
				maint_idle});
			chk("fence_clear", 1'h0, mem_fence);
		end
		issue(32'hF3BF_8F60, 1'h1);
		chk("other_sel", 2'h1, {barrier_done, undefined});
	endtask

	task stop_test;
		if (fail_count == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Reset for four cycles, then the scenarios in turn
	initial begin
		srst = 1'h1;
		instr_valid = 1'h0;
		instr_is32 = 1'h0;
		instr = 32'h0;
		program_counter = 32'h0;
		pc = 32'h0000_1004;
		kick = 1'h0;
		mem_len = 4'h0;
		maint_len = 4'h0;
		repeat (4) @(posedge clk);
		srst <= 1'h0;
		t_compare;
		t_branch;
		t_barrier;
		stop_test;
	end

	// Whole run needs well under a thousand cycles
	initial begin
		repeat (3000) @(posedge clk);
		fail_count++;
		stop_test;
	end
endmodule
